// [dv/gpr_file_model.sv]
// register file model that feeds operands to the compare unit
`timescale 1ns/1ns
`default_nettype none
module gpr_file_model
(
   // clock and load port
   input wire logic clk,
   input wire logic ld_en,
   input wire logic [4:0] ld_idx,
   input wire logic [63:0] ld_data,
   // read ports
   input wire logic [4:0] a_sel,
   input wire logic [4:0] b_sel,
   output logic [63:0] a_data,
   output logic [63:0] b_data
);
   logic [63:0] mem [32];
   always_ff @(posedge clk)
   begin
      if (ld_en)
      begin
         mem[ld_idx] <= ld_data;
      end
   end
   assign a_data = mem[a_sel];
   assign b_data = mem[b_sel];
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for the vector lane compare unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import vec_cmp_pkg::*;
   logic clk, resetn, issue_valid, ld_en, cmp_hit, custom_hit, exception;
   logic cmp_e, cust_e, vld_e;
   insn_s insn, ins;
   result_s wb;
   logic [4:0] ld_idx, src_a_sel, src_b_sel, dest_e;
   logic [63:0] ld_data, a_data, b_data, data_e;
   logic [63:0] mem [32];
   logic [7:0] secs [12];
   int fails = 0, n_checks = 0, cycles = 0;

   gpr_file_model i_gpr (.clk(clk), .ld_en(ld_en), .ld_idx(ld_idx),
      .ld_data(ld_data), .a_sel(src_a_sel), .b_sel(src_b_sel),
      .a_data(a_data), .b_data(b_data));
   vector_lane_compare_unit i_dut (.clk(clk), .resetn(resetn),
      .issue_valid(issue_valid), .insn(insn), .first_source_gpr(a_data),
      .second_source_gpr(b_data), .src_a_sel(src_a_sel),
      .src_b_sel(src_b_sel), .cmp_hit(cmp_hit), .custom_hit(custom_hit),
      .wb(wb), .exception(exception));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(logic [63:0] seen, logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // lane compare, odd codes use half-word lanes, unsigned
   function automatic logic [63:0] calc(logic [7:0] s, logic [63:0] a,
      logic [63:0] b);
      logic [63:0] r;
      logic [15:0] x, y;
      logic t;
      int w;
      r = '0;
      w = s[0] ? 16 : 8;
      for (int i = 0; i < 64; i += w)
      begin
         x = (w == 16) ? a[i+:16] : {8'h00, a[i+:8]};
         y = (w == 16) ? b[i+:16] : {8'h00, b[i+:8]};
         t = (s == 8'h45) ? x > y : (s < 8'h48) ? x <= y :
            (s < 8'h4a) ? x < y : x != y;
         for (int j = 0; j < w; j++)
            r[i+j] = t;
      end
      return r;
   endfunction

   task automatic step(logic v, insn_s i);
      @(posedge clk);
      issue_valid <= v;
      insn <= i;
      #1;
      check(src_a_sel, i.src_a);
      check(src_b_sel, i.src_b);
      check(exception, 1'b0);
      check(wb.valid, vld_e);
      if (vld_e)
      begin
         check(wb.dest, dest_e);
         check(wb.data, data_e);
      end
      cmp_e = i.primary == primary_vector && i.secondary inside {[8'h45:8'h4b]};
      cust_e = i.primary == primary_vector && !cmp_e &&
         i.secondary[7:4] inside {4'hc, 4'hd};
      check(cmp_hit, cmp_e);
      check(custom_hit, cust_e);
      vld_e = v && (cmp_e || cust_e);
      dest_e = i.dest;
      data_e = cmp_e ? calc(i.secondary, mem[i.src_a], mem[i.src_b])
         : zero_word;
   endtask

   initial
   begin
      resetn = 1'b0;
      issue_valid = 1'b0;
      insn = '0;
      ld_en = 1'b0;
      ld_idx = '0;
      ld_data = '0;
      vld_e = 1'b0;
      secs = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'hc3,
         8'hd0, 8'h44, 8'he0, 8'h00};
      void'($urandom(64279));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 32; k++)
      begin
         @(posedge clk);
         mem[k] = (k == 0) ? '0 : (k == 1) ? '1 : {$urandom, $urandom};
         if (k == 3)
            mem[k] = mem[2] ^ 64'h0000_0000_ff00_0001;
         ld_en <= 1'b1;
         ld_idx <= k[4:0];
         ld_data <= mem[k];
      end
      @(posedge clk);
      ld_en <= 1'b0;
      for (int n = 0; n < 400; n++)
      begin
         ins = insn_s'($urandom);
         ins.secondary = (n < 48) ? secs[n % 12] : secs[$urandom % 12];
         if (n < 48 || $urandom % 8 != 0)
            ins.primary = primary_vector;
         if (n < 48)
         begin
            ins.src_a = 5'(n / 12);
            ins.src_b = 5'd3 - ins.src_a;
         end
         else if ($urandom % 4 == 0)
            ins.src_b = ins.src_a;
         step(n < 48 || $urandom % 6 != 0, ins);
      end
      ins = '0;
      ins.primary = primary_vector;
      ins.secondary = sec_half_ne;
      ins.src_b = 5'd1;
      step(1'b1, ins);
      @(posedge clk);
      resetn <= 1'b0;
      issue_valid <= 1'b0;
      #1;
      check(wb.valid, 1'b0);
      check(wb.data, zero_word);
      vld_e = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      step(1'b0, '0);
      step(1'b0, '0);
      conclude();
   end
endmodule
`default_nettype wire

// [hdl/vector_lane_compare_unit.sv]
// vector lane compare datapath with opcode decode
`timescale 1ns/1ns
`default_nettype none
module vector_lane_compare_unit
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // issue from decode stage
   input wire logic issue_valid,
   input wire vec_cmp_pkg::insn_s insn,
   input wire logic [63:0] first_source_gpr,
   input wire logic [63:0] second_source_gpr,
   // decode outputs
   output logic [4:0] src_a_sel,
   output logic [4:0] src_b_sel,
   output logic cmp_hit,
   output logic custom_hit,
   // writeback and exception
   output vec_cmp_pkg::result_s wb,
   output logic exception
);
   import vec_cmp_pkg::*;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   vec_op_e op;
   wire logic is_vector;
   wire logic [3:0] minor;
   assign is_vector = insn.primary == primary_vector;
   assign minor = insn.secondary[minor_hi:minor_lo];
   assign src_a_sel = insn.src_a;
   assign src_b_sel = insn.src_b;

   always_comb
   begin
      op = op_none;
      if (is_vector)
      begin
         case (insn.secondary)
            sec_half_gt: op = op_half_gt;
            sec_byte_le: op = op_byte_le;
            sec_half_le: op = op_half_le;
            sec_byte_lt: op = op_byte_lt;
            sec_half_lt: op = op_half_lt;
            sec_byte_ne: op = op_byte_ne;
            sec_half_ne: op = op_half_ne;
            default:
            begin
               if (minor == minor_custom_one)
                  op = op_custom_one;
               else if (minor == minor_custom_two)
                  op = op_custom_two;
               else
                  op = op_none;
            end
         endcase
      end
   end

   function automatic logic is_custom_op(vec_op_e o);
      return o == op_custom_one || o == op_custom_two;
   endfunction

   assign cmp_hit = op != op_none && !is_custom_op(op);
   assign custom_hit = is_custom_op(op);

   // ----------------------------------------
   // lane compares, unsigned elements
   // ----------------------------------------
   wire logic [63:0] byte_le, byte_lt, byte_ne;
   wire logic [63:0] half_gt, half_le, half_lt, half_ne;

   genvar gi;
   generate
      for (gi = 0; gi < byte_lanes; gi++)
      begin : g_byte
         wire logic [7:0] a;
         wire logic [7:0] b;
         assign a = first_source_gpr[gi*byte_w +: byte_w];
         assign b = second_source_gpr[gi*byte_w +: byte_w];
         assign byte_le[gi*byte_w +: byte_w] = {byte_w{a <= b}};
         assign byte_lt[gi*byte_w +: byte_w] = {byte_w{a < b}};
         assign byte_ne[gi*byte_w +: byte_w] = {byte_w{a != b}};
      end
      for (gi = 0; gi < half_lanes; gi++)
      begin : g_half
         wire logic [15:0] a;
         wire logic [15:0] b;
         assign a = first_source_gpr[gi*half_w +: half_w];
         assign b = second_source_gpr[gi*half_w +: half_w];
         assign half_gt[gi*half_w +: half_w] = {half_w{a > b}};
         assign half_le[gi*half_w +: half_w] = {half_w{a <= b}};
         assign half_lt[gi*half_w +: half_w] = {half_w{a < b}};
         assign half_ne[gi*half_w +: half_w] = {half_w{a != b}};
      end
   endgenerate

   // ----------------------------------------
   // result select
   // ----------------------------------------
   logic [63:0] result;
   always_comb
   begin
      case (op)
         op_half_gt: result = half_gt;
         op_byte_le: result = byte_le;
         op_half_le: result = half_le;
         op_byte_lt: result = byte_lt;
         op_half_lt: result = half_lt;
         op_byte_ne: result = byte_ne;
         op_half_ne: result = half_ne;
         default: result = zero_word;
      endcase
   end

   // ----------------------------------------
   // writeback register
   // ----------------------------------------
   result_s wb_reg;
   result_s wb_next;
   assign wb_next.valid = issue_valid && (cmp_hit || custom_hit);
   assign wb_next.dest = insn.dest;
   assign wb_next.data = result;
   assign exception = 1'b0;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         wb_reg <= '0;
      else
         wb_reg <= wb_next;
   end
   assign wb = wb_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_decode_fields;
      @(posedge clk) disable iff (!resetn)
      issue_valid |-> ##1 (wb.dest == $past(insn.dest));
   endproperty
   a_decode_fields: assert property (p_decode_fields)
      else $error("dest field not carried");

   property p_half_gt;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && is_vector && insn.secondary == sec_half_gt)
      |=> wb.valid && wb.data[15:0] ==
      {16{$past(first_source_gpr[15:0]) > $past(second_source_gpr[15:0])}};
   endproperty
   a_half_gt: assert property (p_half_gt)
      else $error("half greater result wrong");

   property p_byte_le;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_le) |=> wb.data[63:56] ==
      {8{$past(first_source_gpr[63:56]) <= $past(second_source_gpr[63:56])}};
   endproperty
   a_byte_le: assert property (p_byte_le)
      else $error("byte less equal top lane wrong");

   property p_byte_lt;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_lt
      && first_source_gpr[7:0] == second_source_gpr[7:0])
      |=> wb.data[7:0] == 8'h00;
   endproperty
   a_byte_lt: assert property (p_byte_lt)
      else $error("less than true on equal");

   property p_half_ne;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_ne) |=> wb.data[63:48] ==
      {16{$past(first_source_gpr[63:48]) != $past(second_source_gpr[63:48])}};
   endproperty
   a_half_ne: assert property (p_half_ne)
      else $error("half not equal top lane wrong");

   property p_custom_zero;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && custom_hit) |=> wb.valid && wb.data == zero_word;
   endproperty
   a_custom_zero: assert property (p_custom_zero)
      else $error("custom slot result not zero");

   property p_no_exception;
      @(posedge clk) disable iff (!resetn)
      issue_valid |-> ##[0:2] !exception;
   endproperty
   a_no_exception: assert property (p_no_exception)
      else $error("exception raised");

   property p_lane_fill;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_lt) |=>
      (wb.data[31:16] == 16'h0000 || wb.data[31:16] == 16'hffff);
   endproperty
   a_lane_fill: assert property (p_lane_fill)
      else $error("lane not uniform");

   property p_idle;
      @(posedge clk) disable iff (!resetn)
      !issue_valid |=> !wb.valid;
   endproperty
   a_idle: assert property (p_idle)
      else $error("writeback without issue");

   property p_byte_lt_lane;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_lt) |=> wb.valid && wb.data[15:8] ==
      {8{$past(first_source_gpr[15:8]) < $past(second_source_gpr[15:8])}};
   endproperty
   a_byte_lt_lane: assert property (p_byte_lt_lane)
      else $error("byte less than lane wrong");

   property p_half_lt_lane;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_lt) |=> wb.valid && wb.data[47:32] ==
      {16{$past(first_source_gpr[47:32]) < $past(second_source_gpr[47:32])}};
   endproperty
   a_half_lt_lane: assert property (p_half_lt_lane)
      else $error("half less than lane wrong");

   property p_half_lt_equal;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_lt
      && first_source_gpr[15:0] == second_source_gpr[15:0])
      |=> wb.data[15:0] == 16'h0000;
   endproperty
   a_half_lt_equal: assert property (p_half_lt_equal)
      else $error("half less than true on equal");

   property p_byte_ne_top;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_ne) |=> wb.data[63:56] ==
      {8{$past(first_source_gpr[63:56]) != $past(second_source_gpr[63:56])}};
   endproperty
   a_byte_ne_top: assert property (p_byte_ne_top)
      else $error("byte not equal top lane wrong");

   property p_byte_ne_low;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_ne) |=> wb.valid && wb.data[7:0] ==
      {8{$past(first_source_gpr[7:0]) != $past(second_source_gpr[7:0])}};
   endproperty
   a_byte_ne_low: assert property (p_byte_ne_low)
      else $error("byte not equal low lane wrong");

   property p_half_gt_top;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_gt) |=> wb.data[63:48] ==
      {16{$past(first_source_gpr[63:48]) > $past(second_source_gpr[63:48])}};
   endproperty
   a_half_gt_top: assert property (p_half_gt_top)
      else $error("half greater top lane wrong");

   property p_gt_strict;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_gt
      && first_source_gpr[31:16] == second_source_gpr[31:16])
      |=> wb.data[31:16] == 16'h0000;
   endproperty
   a_gt_strict: assert property (p_gt_strict)
      else $error("greater than true on equal");

   property p_half_le_lane;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_half_le) |=> wb.valid && wb.data[31:16] ==
      {16{$past(first_source_gpr[31:16]) <= $past(second_source_gpr[31:16])}};
   endproperty
   a_half_le_lane: assert property (p_half_le_lane)
      else $error("half less equal lane wrong");

   property p_custom_two;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && is_vector && !cmp_hit && minor == minor_custom_two)
      |=> wb.valid && wb.data == zero_word;
   endproperty
   a_custom_two: assert property (p_custom_two)
      else $error("custom slot two not taken");

   property p_custom_one_decode;
      @(posedge clk) disable iff (!resetn)
      (is_vector && minor == minor_custom_one) |-> custom_hit && !cmp_hit;
   endproperty
   a_custom_one_decode: assert property (p_custom_one_decode)
      else $error("custom slot one not decoded");

   property p_not_vector;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && !is_vector) |=> !wb.valid;
   endproperty
   a_not_vector: assert property (p_not_vector)
      else $error("writeback for foreign primary opcode");

   property p_full_width;
      @(posedge clk) disable iff (!resetn)
      (issue_valid && op == op_byte_le
      && first_source_gpr == second_source_gpr)
      |=> wb.data == ~zero_word;
   endproperty
   a_full_width: assert property (p_full_width)
      else $error("result not full width");

   c_half_gt: cover property (@(posedge clk) disable iff (!resetn)
      issue_valid && op == op_half_gt);
   c_byte_ne: cover property (@(posedge clk) disable iff (!resetn)
      issue_valid && op == op_byte_ne);
   c_custom: cover property (@(posedge clk) disable iff (!resetn)
      issue_valid && op == op_custom_two);
   c_byte_le: cover property (@(posedge clk) disable iff (!resetn)
      issue_valid && op == op_byte_le);
   c_custom_one: cover property (@(posedge clk) disable iff (!resetn)
      issue_valid && op == op_custom_one);
endmodule
`default_nettype wire

// [inc/vec_cmp_pkg.sv]
// constants and types for the vector lane compare unit
// Function
// - split word into primary op, dest, two sources, reserved, secondary op
// - vector group with secondary 0x45 selects half-word greater-than
// - 0x46 byte less-or-equal, 0x47 half-word less-or-equal
// - 0x48 byte less-than, 0x49 half-word less-than
// - 0x4a byte not-equal, 0x4b half-word not-equal
// - byte compares use eight independent 8-bit lanes
// - half-word compares use four independent 16-bit lanes
// - lane result is all ones when true, all zeros otherwise
// - greater-than holds when first source exceeds second
// - less-or-equal holds when first source is not above second
// - less-than holds only when first source strictly below second
// - not-equal holds when the two lane elements differ
// - minor opcode 0xc in bits 7..4 marks custom slot one
// - minor opcode 0xd in bits 7..4 marks custom slot two
// - custom slots carry implementation behaviour, here none, result zero
package vec_cmp_pkg;
   localparam int unsigned data_w = 64;
   localparam int unsigned byte_w = 8;
   localparam int unsigned half_w = 16;
   localparam int unsigned byte_lanes = data_w / byte_w;
   localparam int unsigned half_lanes = data_w / half_w;
   localparam logic [5:0] primary_vector = 6'h0a;
   localparam logic [7:0] sec_half_gt = 8'h45;
   localparam logic [7:0] sec_byte_le = 8'h46;
   localparam logic [7:0] sec_half_le = 8'h47;
   localparam logic [7:0] sec_byte_lt = 8'h48;
   localparam logic [7:0] sec_half_lt = 8'h49;
   localparam logic [7:0] sec_byte_ne = 8'h4a;
   localparam logic [7:0] sec_half_ne = 8'h4b;
   localparam logic [3:0] minor_custom_one = 4'hc;
   localparam logic [3:0] minor_custom_two = 4'hd;
   localparam int unsigned minor_hi = 7;
   localparam int unsigned minor_lo = 4;
   localparam logic [63:0] zero_word = 64'h0000_0000_0000_0000;

   typedef struct packed {
      logic [5:0] primary;
      logic [4:0] dest;
      logic [4:0] src_a;
      logic [4:0] src_b;
      logic [2:0] reserved;
      logic [7:0] secondary;
   } insn_s;

   typedef enum {
      op_none,
      op_half_gt,
      op_byte_le,
      op_half_le,
      op_byte_lt,
      op_half_lt,
      op_byte_ne,
      op_half_ne,
      op_custom_one,
      op_custom_two
   } vec_op_e;

   typedef struct packed {
      logic valid;
      logic [4:0] dest;
      logic [63:0] data;
   } result_s;
endpackage
